// *** hdl/trc_pkg.sv ***
/*
 * Shared constants for the tape read clock recovery block: timing counts,
 * phase-detector cell geometry, input synchroniser bit positions, controller states.
 * Assumes a 250 MHz core clock; every timing count below is derived from that period.
 */
package trc_pkg;
  localparam int CLK_NS = 4;
  // read-peak pulse width, a least time, rounds up
  localparam int PEAK_PULSE_NS = 100;
  localparam int PEAK_PULSE_CYC = (PEAK_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // half period of the outgoing read clock, a longest time, rounds down
  localparam int SER_HALF_NS = 40;
  localparam int SER_HALF_CYC = (SER_HALF_NS / CLK_NS) < 1 ? 1 : SER_HALF_NS / CLK_NS;
  // delay from gap interrupt to the preamble midpoint
  localparam int PRE_MID_NS = 8000;
  localparam int PRE_MID_CYC = (PRE_MID_NS / CLK_NS) < 1 ? 1 : PRE_MID_NS / CLK_NS;
  // phase detector: data cell 16 oscillator clocks, clock cell 14
  localparam logic [3:0] DATA_CELL_LAST = 4'hf;
  localparam logic [3:0] DATA_CELL_CENTRE = 4'h8;
  localparam logic [3:0] CLOCK_CELL_LAST = 4'hd;
  localparam logic [3:0] CLOCK_CELL_CENTRE = 4'h7;
  localparam logic [3:0] RETARD_CARRY = 4'hf;
  // synchroniser bit positions
  localparam int SI_PEAK = 0;
  localparam int SI_OSC = 1;
  localparam int SI_WCLK = 2;
  localparam int SI_GAP = 3;
  localparam int SI_SPEED = 4;
  localparam int SI_N = 5;
  localparam int TIMER_W = 13;
  localparam int SER_CNT_W = 5;
  localparam int PULSE_W = 5;
  typedef enum logic [1:0] {TRC_IDLE, TRC_WAIT_GAP, TRC_TIMING, TRC_READ} trc_ctl_e;
endpackage

// *** hdl/trc_read_recovery.sv ***
/*
 * Tape read clock recovery: peak pulse shaping, oscillator-synchronised load strobe,
 * phase detector with advance/retard requests, loop gain control, bit decoder and
 * serial sender with a small bit FIFO. All inputs except core_clk, sys_rst and clk_en are asynchronous pins
 * and are sampled by core_clk; the recovered oscillator and write clock are slow enough
 * (well under 1/6 of core_clk) to be edge-detected after synchronisation.
 */
// Function
// - every detected zero crossing gives one 100 ns read-peak pulse
// - pulse timing carries data into the recovery loop and decoder
// - during a gap the loop tracks the write clock in high gain
// - gain select low means high gain, high means low gain
// - high gain gives about five times the correction strength of low gain
// - high gain through gap and early preamble, low gain for the data field
// - after tape at speed, gap detect starts a timer, gain goes high mid-preamble
// - active-low retard request slows the oscillator; off when deasserted
// - active-low advance request speeds it; only advance, retard, gain drive the loop
// - the pulse synchroniser is clocked by the recovered oscillator clock
// - gain select also qualifies the data decoder
// - in low gain the preamble is ones; first zero is sent with the read clock
// - after the leading zero, data, CRC and postamble follow on the link
// - each read-peak pulse gives one load strobe of one oscillator period
// - data cell is 16 oscillator clocks, clock cell 14, centred on clocks 8 and 7
// - early strobe advances until centre; late one loads two's complement, retards to carry
// - a cell holding any strobe decodes as one, an empty cell as zero
`timescale 1ns/1ps

module trc_bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } trc_fifo_s;

  trc_fifo_s st_reg, st_next;
  logic push, pop;

  assign in_ready = st_reg.cnt != FULL;
  assign out_valid = st_reg.cnt != '0;
  assign out_data = st_reg.mem[st_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == LAST) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == LAST) ? '0 : st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end
endmodule

module trc_read_recovery (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic zero_cross,
  input wire logic recovered_osc_clock,
  input wire logic write_clock,
  input wire logic gap_detect_n,
  input wire logic tape_at_speed,
  output logic read_peak_pulse,
  output logic cell_sync_strobe,
  output logic phase_advance_req_n,
  output logic phase_retard_req_n,
  output logic loop_gain_sel,
  output logic ser_data,
  output logic ser_read_clock,
  output logic read_overrun
);
  typedef struct packed {
    logic [trc_pkg::SI_N-1:0] s1;
    logic [trc_pkg::SI_N-1:0] s2;
    logic [trc_pkg::SI_N-1:0] s3;
    logic [trc_pkg::SI_N-1:0] filt;
    logic [trc_pkg::PULSE_W-1:0] pulse_cnt;
    logic pend;
    logic wpend;
    logic strobe;
    logic [3:0] cell_cnt;
    logic hit;
    logic adv;
    logic ret;
    logic [3:0] ret_cnt;
    logic gain;
    logic gain_q;
    logic framing;
    logic push_v;
    logic push_bit;
    trc_pkg::trc_ctl_e ctl;
    logic [trc_pkg::TIMER_W-1:0] timer;
    logic busy;
    logic [trc_pkg::SER_CNT_W-1:0] ser_cnt;
    logic ser_clk;
    logic ser_bit;
    logic overrun;
  } trc_state_s;

  trc_state_s st_reg, st_next;
  logic fifo_in_ready, fifo_out_valid, fifo_out_bit;

  assign read_peak_pulse = st_reg.pulse_cnt != '0;
  assign cell_sync_strobe = st_reg.strobe;
  assign phase_advance_req_n = ~st_reg.adv;
  assign phase_retard_req_n = ~st_reg.ret;
  assign loop_gain_sel = st_reg.gain;
  assign ser_data = st_reg.ser_bit;
  assign ser_read_clock = st_reg.ser_clk;
  assign read_overrun = st_reg.overrun;

  // the sender pops only when idle, so a slow link backs the FIFO up to the decoder
  trc_bit_fifo #(.WIDTH(1), .DEPTH(4)) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_valid(st_reg.push_v),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.push_bit),
    .out_valid(fifo_out_valid),
    .out_ready(~st_reg.busy),
    .out_data(fifo_out_bit)
  );

  always_comb begin
    logic [trc_pkg::SI_N-1:0] rise, fall;
    logic tick, ref_ev, wrap, cell_bit;
    logic [3:0] last, centre;
    rise = '0;
    fall = '0;
    tick = 1'b0;
    ref_ev = 1'b0;
    wrap = 1'b0;
    cell_bit = 1'b0;
    last = st_reg.gain ? trc_pkg::DATA_CELL_LAST : trc_pkg::CLOCK_CELL_LAST;
    centre = st_reg.gain ? trc_pkg::DATA_CELL_CENTRE : trc_pkg::CLOCK_CELL_CENTRE;
    st_next = st_reg;
    st_next.s1 = {tape_at_speed, gap_detect_n, write_clock, recovered_osc_clock, zero_cross};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < trc_pkg::SI_N; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.filt[i] = st_reg.s3[i];
        rise[i] = st_reg.s3[i] & ~st_reg.filt[i];
        fall[i] = ~st_reg.s3[i] & st_reg.filt[i];
      end
    end
    st_next.push_v = 1'b0;

    if (rise[trc_pkg::SI_PEAK]) begin
      st_next.pulse_cnt = trc_pkg::PULSE_W'(trc_pkg::PEAK_PULSE_CYC);
    end else if (st_reg.pulse_cnt != '0) begin
      st_next.pulse_cnt = st_reg.pulse_cnt - 1'b1;
    end

    // oscillator edges clock the strobe and phase logic
    tick = rise[trc_pkg::SI_OSC];
    // until the preamble midpoint the write clock is the phase reference, afterwards the data
    ref_ev = tick && (st_reg.gain ? st_reg.pend : st_reg.wpend);
    if (tick) begin
      st_next.strobe = st_reg.pend;
      st_next.pend = 1'b0;
      st_next.wpend = 1'b0;
      wrap = st_reg.cell_cnt == last;
      st_next.cell_cnt = wrap ? 4'h0 : st_reg.cell_cnt + 4'h1;
      if (st_reg.adv && st_reg.cell_cnt == centre) begin
        st_next.adv = 1'b0;
      end
      if (st_reg.ret) begin
        st_next.ret_cnt = st_reg.ret_cnt + 4'h1;
        if (st_reg.ret_cnt == trc_pkg::RETARD_CARRY) begin
          st_next.ret = 1'b0;
        end
      end
      if (ref_ev) begin
        if (st_reg.cell_cnt < centre) begin
          st_next.adv = 1'b1;
          st_next.ret = 1'b0;
        end else if (st_reg.cell_cnt > centre) begin
          st_next.ret = 1'b1;
          st_next.adv = 1'b0;
          st_next.ret_cnt = centre - st_reg.cell_cnt;
        end
      end
      cell_bit = st_reg.hit | ref_ev;
      st_next.hit = wrap ? 1'b0 : cell_bit;
      if (wrap) begin
        st_next.gain_q = st_reg.gain;
        if (!st_reg.gain_q) begin
          st_next.framing = 1'b0;
        end else if (!st_reg.framing && !cell_bit) begin
          st_next.framing = 1'b1;
          st_next.push_v = 1'b1;
          st_next.push_bit = 1'b0;
        end else if (st_reg.framing) begin
          st_next.push_v = 1'b1;
          st_next.push_bit = cell_bit;
        end
      end
    end
    if (rise[trc_pkg::SI_PEAK]) begin
      st_next.pend = 1'b1;
    end
    if (rise[trc_pkg::SI_WCLK]) begin
      st_next.wpend = 1'b1;
    end

    // gain sequencing; low output is high gain, five times the pump current
    case (st_reg.ctl)
      trc_pkg::TRC_IDLE: begin
        st_next.gain = 1'b0;
        if (st_reg.filt[trc_pkg::SI_SPEED]) begin
          st_next.ctl = trc_pkg::TRC_WAIT_GAP;
        end
      end
      trc_pkg::TRC_WAIT_GAP: begin
        if (fall[trc_pkg::SI_GAP]) begin
          st_next.ctl = trc_pkg::TRC_TIMING;
          st_next.timer = '0;
        end
      end
      trc_pkg::TRC_TIMING: begin
        st_next.timer = st_reg.timer + 1'b1;
        if (st_reg.timer == trc_pkg::TIMER_W'(trc_pkg::PRE_MID_CYC - 1)) begin
          st_next.ctl = trc_pkg::TRC_READ;
          st_next.gain = 1'b1;
        end
      end
      trc_pkg::TRC_READ: begin
        if (fall[trc_pkg::SI_GAP]) begin
          st_next.ctl = trc_pkg::TRC_TIMING;
          st_next.timer = '0;
          st_next.gain = 1'b0;
        end
      end
      default: begin
        st_next.ctl = trc_pkg::TRC_IDLE;
      end
    endcase
    if (!st_reg.filt[trc_pkg::SI_SPEED]) begin
      st_next.ctl = trc_pkg::TRC_IDLE;
      st_next.gain = 1'b0;
    end

    // a bit lost to a full FIFO is remembered until the next gap
    if (st_reg.push_v && !fifo_in_ready) begin
      st_next.overrun = 1'b1;
    end else if (fall[trc_pkg::SI_GAP]) begin
      st_next.overrun = 1'b0;
    end

    // data changes with the read clock low, host samples on its rising edge
    if (st_reg.busy) begin
      st_next.ser_cnt = st_reg.ser_cnt + 1'b1;
      if (st_reg.ser_cnt == trc_pkg::SER_CNT_W'(trc_pkg::SER_HALF_CYC - 1)) begin
        st_next.ser_clk = 1'b1;
      end
      if (st_reg.ser_cnt == trc_pkg::SER_CNT_W'(2 * trc_pkg::SER_HALF_CYC - 1)) begin
        st_next.ser_clk = 1'b0;
        st_next.busy = 1'b0;
      end
    end else if (fifo_out_valid) begin
      st_next.busy = 1'b1;
      st_next.ser_cnt = '0;
      st_next.ser_bit = fifo_out_bit;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  a_peak_width: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    $rose(read_peak_pulse) |-> ##24 read_peak_pulse ##1 !read_peak_pulse)
    else $error("read peak pulse width wrong");
  a_gap_high_gain: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    (st_reg.ctl == trc_pkg::TRC_READ && st_reg.s2[trc_pkg::SI_GAP] == st_reg.s3[trc_pkg::SI_GAP]
      && !st_reg.s3[trc_pkg::SI_GAP] && st_reg.filt[trc_pkg::SI_GAP]) |=> !loop_gain_sel)
    else $error("gain not high at gap");
  a_gain_midpoint: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    $rose(loop_gain_sel) |-> $past(st_reg.ctl) == trc_pkg::TRC_TIMING
      && $past(st_reg.timer) == trc_pkg::TIMER_W'(trc_pkg::PRE_MID_CYC - 1))
    else $error("gain select rose off the preamble midpoint");
  a_pump_exclusive: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(!phase_advance_req_n && !phase_retard_req_n))
    else $error("advance and retard both asserted");
  a_retard_carry: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    (st_reg.ret && st_reg.ret_cnt == trc_pkg::RETARD_CARRY && st_reg.s3[trc_pkg::SI_OSC]
      && st_reg.s2[trc_pkg::SI_OSC] && !st_reg.filt[trc_pkg::SI_OSC]
      && !(st_reg.gain ? st_reg.pend : st_reg.wpend)) |=> phase_retard_req_n)
    else $error("retard not released at carry");
  a_strobe_follows: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    $rose(read_peak_pulse) |-> ##[1:200] cell_sync_strobe)
    else $error("no load strobe for peak pulse");
  a_start_zero: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    $rose(st_reg.framing) |-> st_reg.push_v && !st_reg.push_bit && st_reg.gain_q)
    else $error("frame did not start with a zero bit");
  a_gain_sync: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    $changed(st_reg.gain_q) |-> st_reg.cell_cnt == 4'h0)
    else $error("decoder gain changed inside a cell");
  a_ser_stable: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    ser_read_clock |-> $stable(ser_data))
    else $error("serial data moved while read clock high");
endmodule

// *** tb/trc_host_rx.sv ***
/*
 * Host-side serial receiver model for the read link: waits for the first zero as frame start, keeps 16 bits.
 * Assumes ser_data is steady at every rising edge of ser_read_clock; it drives nothing back.
 */
`timescale 1ns/1ps
module trc_host_rx (
  input wire logic sys_rst,
  input wire logic ser_data,
  input wire logic ser_read_clock,
  output logic [4:0] n_bits,
  output logic [15:0] first_bits
);
  // ones ahead of the marker are preamble and are dropped, as the real receiver would
  always @(posedge ser_read_clock or posedge sys_rst) begin
    if (sys_rst) begin
      n_bits <= 5'h00;
      first_bits <= 16'h0000;
    end else if ((n_bits != 5'h00 || ser_data == 1'b0) && n_bits < 5'h10) begin
      first_bits <= {first_bits[14:0], ser_data};
      n_bits <= n_bits + 5'h01;
    end
  end
endmodule

// *** tb/trc_read_recovery_tb_top.sv ***
/*
 * Self-checking bench for the tape read clock recovery block: peak pulse table, strobe width, correction
 * lengths, gain timing and the framed bits on the read link.
 * Assumes trc_host_rx as the far side; oscillator and write clock run free, unrelated to core_clk.
 */
`timescale 1ns/1ps
module trc_read_recovery_tb_top;
  typedef struct {int gap; int exp_hi; int exp_st;} trc_row_s;
  localparam int LIMIT = 30000;
  trc_row_s rows [4] = '{'{0, 25, 1}, '{40, 50, 2}, '{60, 50, 2}, '{100, 50, 2}};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic zero_cross = 1'b0;
  logic recovered_osc_clock = 1'b0;
  logic write_clock = 1'b0;
  logic gap_detect_n = 1'b1;
  logic tape_at_speed = 1'b0;
  logic read_peak_pulse, cell_sync_strobe, phase_advance_req_n, phase_retard_req_n;
  logic loop_gain_sel, ser_data, ser_read_clock, read_overrun;
  logic [4:0] n_bits;
  logic [15:0] first_bits;
  logic train_on = 1'b0;
  logic ones = 1'b1;
  logic [15:0] pat = 16'h5900;
  logic rc_d = 1'b0;
  int n_fail = 0, n_tests = 0, cyc = 0, pk_hi = 0, st_run = 0, st_count = 0;
  int adv_run = 0, ret_run = 0, n_corr = 0, n_clk = 0;

  always #2 core_clk = ~core_clk;
  always #1000 write_clock = ~write_clock;
  // odd offset keeps oscillator edges away from core_clk edges
  initial begin
    #13;
    forever #40 recovered_osc_clock = ~recovered_osc_clock;
  end

  trc_read_recovery u_trc_read_recovery (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .zero_cross(zero_cross),
    .recovered_osc_clock(recovered_osc_clock), .write_clock(write_clock), .gap_detect_n(gap_detect_n),
    .tape_at_speed(tape_at_speed), .read_peak_pulse(read_peak_pulse), .cell_sync_strobe(cell_sync_strobe),
    .phase_advance_req_n(phase_advance_req_n), .phase_retard_req_n(phase_retard_req_n),
    .loop_gain_sel(loop_gain_sel), .ser_data(ser_data), .ser_read_clock(ser_read_clock),
    .read_overrun(read_overrun)
  );
  trc_host_rx u_trc_host_rx (
    .sys_rst(sys_rst), .ser_data(ser_data), .ser_read_clock(ser_read_clock),
    .n_bits(n_bits), .first_bits(first_bits)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // called just after a core_clk edge; pin held 4 cycles so the input filter takes it
  task automatic peak();
    zero_cross <= 1'b1;
    repeat (4) @(posedge core_clk);
    zero_cross <= 1'b0;
  endtask

  // one peak every 16 oscillator ticks, so each low-gain cell holds at most one
  // each slot decides once between preamble and pattern, so a change of ones mid-slot skips no bit
  always begin
    repeat (16) @(posedge recovered_osc_clock);
    if (train_on && !ones) begin
      if (pat[15]) begin
        @(posedge core_clk);
        peak();
      end
      pat = {pat[14:0], 1'b0};
    end else if (train_on) begin
      @(posedge core_clk);
      peak();
    end
  end

  always @(posedge core_clk) begin
    if (!sys_rst) begin
      if (read_peak_pulse === 1'b1) pk_hi++;
      if (cell_sync_strobe === 1'b1) st_run++;
      else if (st_run != 0) begin
        check(16'(st_run), 16'h0014);
        st_count++;
        st_run = 0;
      end
      if (phase_advance_req_n === 1'b0) adv_run++;
      else if (adv_run != 0) begin
        check(16'(adv_run <= 160), 16'h0001);
        n_corr++;
        adv_run = 0;
      end
      if (phase_retard_req_n === 1'b0) ret_run++;
      else if (ret_run != 0) begin
        check(16'(ret_run <= 160), 16'h0001);
        n_corr++;
        ret_run = 0;
      end
      check({15'h0000, phase_advance_req_n | phase_retard_req_n}, 16'h0001);
      if (ser_read_clock === 1'b1 && rc_d !== 1'b1) n_clk++;
      rc_d = ser_read_clock;
    end
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    check({12'h000, loop_gain_sel, phase_advance_req_n, phase_retard_req_n, read_overrun}, 16'h0006);
    foreach (rows[i]) begin
      pk_hi = 0;
      st_count = 0;
      peak();
      if (rows[i].gap != 0) begin
        repeat (rows[i].gap - 4) @(posedge core_clk);
        peak();
      end
      repeat (150) @(posedge core_clk);
      check(16'(pk_hi), 16'(rows[i].exp_hi));
      check(16'(st_count), 16'(rows[i].exp_st));
    end
    // a pin pulse that comes and goes while the clock enable is low must leave no trace
    pk_hi = 0;
    clk_en <= 1'b0;
    peak();
    repeat (2) @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (40) @(posedge core_clk);
    check(16'(pk_hi), 16'h0000);
    check({15'h0000, read_peak_pulse}, 16'h0000);
    tape_at_speed <= 1'b1;
    train_on = 1'b1;
    repeat (20) @(posedge core_clk);
    gap_detect_n <= 1'b0;
    repeat (1995) @(posedge core_clk);
    check({15'h0000, loop_gain_sel}, 16'h0000);
    gap_detect_n <= 1'b1;
    repeat (15) @(posedge core_clk);
    check({15'h0000, loop_gain_sel}, 16'h0001);
    // eight cells of preamble ones: nothing may leave on the link yet
    repeat (2560) @(posedge core_clk);
    check(16'(n_clk), 16'h0000);
    ones = 1'b0;
    repeat (6400) @(posedge core_clk);
    check(first_bits, 16'h5900);
    check({11'h000, n_bits}, 16'h0010);
    check(16'(n_clk >= 16), 16'h0001);
    check({15'h0000, read_overrun}, 16'h0000);
    check(16'(n_corr != 0), 16'h0001);
    gap_detect_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    check({15'h0000, loop_gain_sel}, 16'h0000);
    summarize();
  end
endmodule
